/* File: common/dac_host_pkg.sv */
// constants and carrier types for the dual converter write controller
package dac_host_pkg;
   localparam int code_width = 8;
   localparam int clk_period_ns = 8;
   // device timing minima, ns
   localparam int setup_sel_ns = 50;
   localparam int setup_data_ns = 25;
   localparam int strobe_low_ns = 50;
   localparam int hold_data_ns = 10;
   localparam int hold_pick_ns = 10;
   // whole clock cycles that cover a span in ns
   function automatic int ns_to_cycles(input int span_ns);
      return (span_ns + clk_period_ns - 1) / clk_period_ns;
   endfunction
   localparam int setup_cycles = ns_to_cycles(setup_sel_ns);
   localparam int strobe_cycles = ns_to_cycles(strobe_low_ns);
   localparam int hold_ns = (hold_data_ns > hold_pick_ns) ? hold_data_ns : hold_pick_ns;
   localparam int hold_cycles = ns_to_cycles(hold_ns);
   localparam int data_setup_cycles = ns_to_cycles(setup_data_ns);
   localparam logic [7:0] reset_code = 8'h00;
   localparam logic [7:0] bipolar_zero = 8'h80;
   localparam logic chan_a = 1'b0;
   localparam logic chan_b = 1'b1;

   typedef struct packed {
      logic select_n;
      logic strobe_n;
      logic channel_pick;
      logic [7:0] input_bus;
   } dac_pins_t;

   typedef struct packed {
      logic channel;
      logic [7:0] code;
   } write_req_t;
endpackage

/* File: design/phase_timer.sv */
// down counter that times each phase of a write cycle
`timescale 1ns/10ps
module phase_timer #(
   parameter int width = 4
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [width-1:0] count,
   output logic done
);
   logic [width-1:0] cnt_q;

   if (width < 1)
   begin : g_width_low
      $error("phase_timer width too small");
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         cnt_q <= '0;
      else if (load)
         cnt_q <= count;
      else if (cnt_q != '0)
         cnt_q <= cnt_q - 1'b1;
   end

   // done must not look at load: the caller derives load from done
   assign done = (cnt_q == '0);
endmodule

/* File: design/dac_write_host.sv */
// host controller that loads either channel latch of a dual converter
`timescale 1ns/10ps
module dac_write_host #(
   parameter int timer_width = 4,
   parameter int setup_count = dac_host_pkg::setup_cycles,
   parameter int strobe_count = dac_host_pkg::strobe_cycles,
   parameter int hold_count = dac_host_pkg::hold_cycles
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire dac_host_pkg::write_req_t req,
   output logic req_ready,
   output logic write_done,
   output dac_host_pkg::dac_pins_t pins,
   output logic [7:0] shadow_a,
   output logic [7:0] shadow_b
);
   typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold} state_t;

   localparam int tw = timer_width;

   // every phase needs one cycle at least and must fit the timer
   if (timer_width < 1 || timer_width > 30 || setup_count < 1 || strobe_count < 1 || hold_count < 1)
   begin : g_count_low
      $error("phase counts or timer width out of range");
   end
   if (setup_count >= (1 << tw) || strobe_count >= (1 << tw) || hold_count >= (1 << tw))
   begin : g_count_high
      $error("phase counts exceed timer width");
   end

   state_t state_q;
   dac_host_pkg::write_req_t held_q;
   logic tload;
   logic [tw-1:0] tcount;
   logic tdone;
   logic take;
   logic setup_end;
   logic strobe_end;
   logic hold_end;

   // timer reload for the phase that is about to start
   function automatic logic [tw-1:0] phase_length(input state_t phase);
      case (phase)
         st_setup:
            return tw'(setup_count - 1);
         st_strobe:
            return tw'(strobe_count - 1);
         st_hold:
            return tw'(hold_count - 1);
         default:
            return '0;
      endcase
   endfunction

   // true on the last cycle of the given phase
   function automatic logic phase_end(input state_t now, input state_t phase, input logic expired);
      return (now == phase) && expired;
   endfunction

   assign take = (state_q == st_idle) && req_valid;
   assign setup_end = phase_end(state_q, st_setup, tdone);
   assign strobe_end = phase_end(state_q, st_strobe, tdone);
   assign hold_end = phase_end(state_q, st_hold, tdone);

   ////////////////////////////////////////////////////////////////////////////
   // phase sequencing

   always_comb
   begin
      tload = 1'b0;
      tcount = '0;
      case (state_q)
         st_idle:
         begin
            tload = req_valid;
            tcount = phase_length(st_setup);
         end
         st_setup:
         begin
            tload = tdone;
            tcount = phase_length(st_strobe);
         end
         st_strobe:
         begin
            tload = tdone;
            tcount = phase_length(st_hold);
         end
         default:
         begin
            tload = 1'b0;
            tcount = '0;
         end
      endcase
   end

   phase_timer #(.width(tw)) timer (
      .mclk(mclk),
      .reset_n(reset_n),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         state_q <= st_idle;
      else
      begin
         case (state_q)
            st_idle:
               if (req_valid)
                  state_q <= st_setup;
            st_setup:
               if (tdone)
                  state_q <= st_strobe;
            st_strobe:
               if (tdone)
                  state_q <= st_hold;
            st_hold:
               if (tdone)
                  state_q <= st_idle;
            default:
               state_q <= st_idle;
         endcase
      end
   end

   // request captured once so the shadow update uses the channel and code of this cycle
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         held_q <= '0;
      else if (state_q == st_idle && req_valid)
         held_q <= req;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive

   logic select_n_q;
   logic strobe_n_q;
   logic pick_q;
   logic [7:0] bus_q;

   // select opens the cycle and is released only after the hold phase
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         select_n_q <= 1'b1;
      else if (take)
         select_n_q <= 1'b0;
      else if (hold_end || state_q == st_idle)
         select_n_q <= 1'b1;
   end

   // strobe falls only after the select setup, and only inside select
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         strobe_n_q <= 1'b1;
      else if (setup_end)
         strobe_n_q <= 1'b0;
      else if (strobe_end || state_q != st_strobe)
         strobe_n_q <= 1'b1;
   end

   // pick and bus change only on a take, so they hold through the cycle
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pick_q <= dac_host_pkg::chan_a;
         bus_q <= dac_host_pkg::reset_code;
      end
      else if (take)
      begin
         pick_q <= req.channel;
         bus_q <= req.code;
      end
   end

   assign pins = '{select_n: select_n_q, strobe_n: strobe_n_q, channel_pick: pick_q, input_bus: bus_q};

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         req_ready <= 1'b0;
      else
         req_ready <= (state_q == st_idle && !req_valid) || hold_end;
   end

   ////////////////////////////////////////////////////////////////////////////
   // completion and shadow copies of each latch

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         write_done <= 1'b0;
      else
         write_done <= strobe_end;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shadow_a <= dac_host_pkg::reset_code;
         shadow_b <= dac_host_pkg::reset_code;
      end
      else if (strobe_end)
      begin
         if (held_q.channel == dac_host_pkg::chan_a)
            shadow_a <= held_q.code;
         else
            shadow_b <= held_q.code;
      end
   end
endmodule

/* File: testbench/dual_latch_model.sv */
// behavioural model of the dual converter input latches
`timescale 1ns/10ps
module dual_latch_model (
   input wire logic select_n,
   input wire logic strobe_n,
   input wire logic channel_pick,
   input wire logic [7:0] input_bus,
   output logic [7:0] latch_a,
   output logic [7:0] latch_b
);
   // the latch named by channel_pick is transparent while select and strobe low, holding otherwise
   always_latch
   begin
      if (!select_n && !strobe_n && !channel_pick)
         latch_a <= input_bus;
   end
   always_latch
   begin
      if (!select_n && !strobe_n && channel_pick)
         latch_b <= input_bus;
   end
endmodule

/* File: testbench/dac_write_host_chk.sv */
// assertions on the write controller pins
`timescale 1ns/10ps
module dac_write_host_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic write_done,
   input wire dac_host_pkg::dac_pins_t pins,
   input wire logic [7:0] shadow_a,
   input wire logic [7:0] shadow_b
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_strobe_in_select: assert property (!pins.strobe_n |-> !pins.select_n)
      else $error("strobe low outside select");
   a_setup_span: assert property ($fell(pins.select_n) |-> pins.strobe_n [*7] ##1 !pins.strobe_n)
      else $error("select to strobe spacing wrong");
   a_strobe_width: assert property ($fell(pins.strobe_n) |-> !pins.strobe_n [*7] ##1 pins.strobe_n)
      else $error("strobe width wrong");
   a_bus_steady: assert property (!pins.select_n && !$past(pins.select_n) |->
      $stable({pins.channel_pick, pins.input_bus}))
      else $error("bus or pick moved inside select");
   a_done_shadow: assert property ($rose(pins.strobe_n) |->
      write_done && (pins.channel_pick ? shadow_b : shadow_a) == pins.input_bus)
      else $error("done or shadow wrong after capture");
   a_select_release: assert property ($rose(pins.strobe_n) |->
      !pins.select_n ##1 !pins.select_n ##1 pins.select_n)
      else $error("select released without hold");
   a_done_pulse: assert property (write_done |=> !write_done)
      else $error("done pulse longer than one cycle");
endmodule
bind dac_write_host dac_write_host_chk dac_write_host_chk_i (.mclk(mclk), .reset_n(reset_n),
   .write_done(write_done), .pins(pins), .shadow_a(shadow_a), .shadow_b(shadow_b));

/* File: testbench/dac_write_host_bench.sv */
// bench for the dual converter write controller
`timescale 1ns/10ps
module dac_write_host_bench;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   dac_host_pkg::write_req_t req = '0;
   logic req_ready;
   logic write_done;
   dac_host_pkg::dac_pins_t pins;
   logic [7:0] shadow_a;
   logic [7:0] shadow_b;
   logic [7:0] latch_a;
   logic [7:0] latch_b;
   int n_mismatch = 0;
   int total_checks = 0;
   always #4 mclk = ~mclk;
   dac_write_host dac_write_host_i (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .write_done(write_done), .pins(pins), .shadow_a(shadow_a), .shadow_b(shadow_b));
   dual_latch_model dual_latch_model_i (.select_n(pins.select_n), .strobe_n(pins.strobe_n),
      .channel_pick(pins.channel_pick), .input_bus(pins.input_bus), .latch_a(latch_a), .latch_b(latch_b));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // waits for ready so a request is never offered while the controller is busy
   task automatic do_write(input logic ch, input logic [7:0] code);
      int i;
      for (i = 0; i < 40 && req_ready !== 1'b1; i++)
         @(negedge mclk);
      chk({7'h00, req_ready}, 8'h01);
      req_valid = 1'b1;
      req = '{channel: ch, code: code};
      @(negedge mclk);
      req_valid = 1'b0;
      for (i = 0; i < 40 && write_done !== 1'b1; i++)
         @(negedge mclk);
      chk({7'h00, write_done}, 8'h01);
      chk({7'h00, pins.strobe_n}, 8'h01);
      @(negedge mclk);
      chk({7'h00, write_done}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic test_chan_a;
      do_write(dac_host_pkg::chan_a, 8'h5a);
      chk(latch_a, 8'h5a);
      chk(shadow_a, 8'h5a);
      chk({7'h00, pins.channel_pick}, {7'h00, dac_host_pkg::chan_a});
      $display("test chan a done");
   endtask
   task automatic test_chan_b;
      do_write(dac_host_pkg::chan_b, 8'ha5);
      chk(latch_b, 8'ha5);
      chk(latch_a, 8'h5a);
      chk(shadow_b, 8'ha5);
      chk({7'h00, pins.channel_pick}, {7'h00, dac_host_pkg::chan_b});
      chk(pins.input_bus, 8'ha5);
      $display("test chan b done");
   endtask
   task automatic test_limits;
      do_write(dac_host_pkg::chan_a, 8'hff);
      chk(latch_a, 8'hff);
      do_write(dac_host_pkg::chan_a, 8'h00);
      chk(latch_a, 8'h00);
      chk(latch_b, 8'ha5);
      do_write(dac_host_pkg::chan_b, dac_host_pkg::bipolar_zero);
      chk(latch_b, 8'h80);
      chk(shadow_b, 8'h80);
      $display("test limits done");
   endtask
   // reset in the setup phase: pins go idle, the latch keeps its code
   task automatic test_reset;
      int i;
      for (i = 0; i < 40 && req_ready !== 1'b1; i++)
         @(negedge mclk);
      req_valid = 1'b1;
      req = '{channel: dac_host_pkg::chan_a, code: 8'hc3};
      @(negedge mclk);
      req_valid = 1'b0;
      repeat (3) @(negedge mclk);
      chk({7'h00, pins.select_n}, 8'h00);
      reset_n = 1'b0;
      @(negedge mclk);
      chk({4'h0, pins.select_n, pins.strobe_n, write_done, req_ready}, 8'h0c);
      chk(shadow_b, dac_host_pkg::reset_code);
      chk(latch_a, 8'h00);
      reset_n = 1'b1;
      @(negedge mclk);
      chk({7'h00, req_ready}, 8'h01);
      do_write(dac_host_pkg::chan_b, 8'h3c);
      chk(latch_b, 8'h3c);
      chk(shadow_b, 8'h3c);
      chk(latch_a, 8'h00);
      $display("test reset done");
   endtask
   initial
   begin
      repeat (8) @(negedge mclk);
      reset_n = 1'b1;
      test_chan_a();
      test_chan_b();
      test_limits();
      test_reset();
      report_and_stop();
   end
   initial
   begin
      // about twenty cycles per write, six full writes and one cut short by reset, wide margin
      repeat (1000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
